// [logic/uart_baud_gen.sv]
// Baud tick generator: power-of-two prescale, times two, divisor latch, fractional stretch
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_baud_gen
    import uart_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [2:0]  clockDivBits,
    input  wire logic [15:0] divisor,
    input  wire logic [15:0] fracDiv,
    input  wire logic        fracEnable,
    output logic             tick16
);
    typedef struct packed {
        logic [6:0]  pre;
        logic        half;
        logic [15:0] cnt;
        logic [11:0] acc;
        logic        stretch;
        logic        tick;
    } baud_state_t;
    baud_state_t st, next_st;
    logic [6:0]  preTop;
    logic [12:0] sum;

    assign preTop = 7'(({6'h00, 1'b1} << clockDivBits) - 7'h01);
    assign tick16 = st.tick;
    // 11-bit N accumulated against 2048; a carry adds one extra divisor-length wait
    assign sum = {1'b0, st.acc} + {2'b00, fracDiv[`FRAC_N_WIDTH-1:0]};

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.pre >= preTop) begin
            next_st.pre = 7'h00;
            next_st.half = ~st.half;
            if (st.half) begin
                if (st.cnt + 16'h0001 >= divisor || divisor == 16'h0000) begin
                    next_st.cnt = 16'h0000;
                    if (fracEnable && st.stretch) begin
                        next_st.stretch = 1'b0;
                    end else begin
                        next_st.tick = 1'b1;
                        if (fracEnable) begin
                            next_st.acc = sum[11:0] & 12'h7FF;
                            next_st.stretch = sum[11];
                        end
                    end
                end else begin
                    next_st.cnt = st.cnt + 16'h0001;
                end
            end
        end else begin
            next_st.pre = st.pre + 7'h01;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : uart_baud_gen

// [logic/uart_cfg.svh]
// Register offsets, field positions, reset values and timing constants of the UART
`ifndef UART_NET_CFG_SVH
`define UART_NET_CFG_SVH
`define OFS_DATA        4'h0
`define OFS_IEN         4'h1
`define OFS_IID         4'h2
`define OFS_LCR         4'h3
`define OFS_MCR         4'h4
`define OFS_LSR         4'h5
`define OFS_MSR         4'h6
`define OFS_SCR         4'h7
`define OFS_FRAC        4'h8
`define OFS_NEN         4'h9
`define OFS_NIID        4'hA
`define OFS_NADR        4'hB
`define OFS_DIVH        4'hC
`define OFS_ISTAT       4'hD
`define OFS_IMASK       4'hE
`define OFS_CD          4'hF
`define LCR_DLAB        7
`define LCR_PEN         3
`define LCR_EPS         4
`define LCR_STB         2
`define NEN_ENABLE      7
`define NEN_ADDRFLAG    0
`define IEN_RXFULL      0
`define IEN_TXEMPTY     1
`define IEN_LINE        2
`define LSR_TEMT        6
`define LSR_THRE        5
`define RESET_DIV       16'h0001
`define RESET_FRAC      16'h0800
`define RESET_LCR       8'h03
`define FRAC_N_WIDTH    11
`define FRAC_ONE        12'h800
`define OVERSAMPLE      5'h10
`define HALF_BIT        5'h08
`define EV_RX           0
`define EV_TX           1
`define EV_LINE         2
`define EV_ADDR         3
`endif

// [logic/uart_link.sv]
// Serial transmitter and receiver working on the 16x oversample tick
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_link
    import uart_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       tick16,
    input  wire logic [1:0] wordLen,
    input  wire logic       twoStop,
    input  wire logic       parityEn,
    input  wire logic       parityEven,
    input  wire logic       nineBit,
    input  wire logic       ninthTx,
    input  wire logic       txStart,
    input  wire logic [7:0] txData,
    output logic            txBusy,
    output logic            txLine,
    input  wire logic       rxLine,
    output logic            rxDone,
    output logic [7:0]      rxData,
    output logic            rxNinth,
    output logic            rxParityErr,
    output logic            rxFrameErr
);
    typedef struct packed {
        link_state_t txSt;
        logic [3:0]  txTick;
        logic [3:0]  txBit;
        logic [8:0]  txSh;
        logic        txOut;
        link_state_t rxSt;
        logic [3:0]  rxTick;
        logic [3:0]  rxBit;
        logic [8:0]  rxSh;
        logic        done;
        logic [7:0]  data;
        logic        ninth;
        logic        perr;
        logic        ferr;
    } link_t;
    link_t st, next_st;
    logic [3:0] nBits;
    logic [3:0] txStops;
    logic [7:0] txMasked;
    logic [8:0] rxWord;

    // Extra bit is either parity or the ninth address/data flag, never both
    assign nBits = 4'h5 + {2'b00, wordLen} + ((parityEn | nineBit) ? 4'h1 : 4'h0);
    assign txStops = twoStop ? 4'h2 : 4'h1;
    // Parity covers only the bits of the selected word length
    assign txMasked = txData & (8'hFF >> (2'h3 - wordLen));
    assign rxWord = st.rxSh >> (4'h9 - nBits);
    assign txBusy = st.txSt != LINK_IDLE;
    assign txLine = st.txOut;
    assign rxDone = st.done;
    assign rxData = st.data;
    assign rxNinth = st.ninth;
    assign rxParityErr = st.perr;
    assign rxFrameErr = st.ferr;

    function automatic logic [8:0] place_extra(input logic [7:0] d, input logic [1:0] wl,
                                               input logic x);
        logic [8:0] r;
        r = {1'b0, d} & ({1'b0, 8'hFF} >> (2'h3 - wl));
        r[4'h5 + {2'b00, wl}] = x;
        return r;
    endfunction : place_extra

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.txSt)
            LINK_IDLE: begin
                next_st.txOut = 1'b1;
                if (txStart) begin
                    next_st.txSh = place_extra(txData, wordLen,
                        nineBit ? ninthTx : (^txMasked ^ ~parityEven));
                    if (!(parityEn | nineBit)) next_st.txSh = {1'b0, txData};
                    next_st.txSt = LINK_START;
                    next_st.txTick = 4'h0;
                end
            end
            LINK_START: begin
                next_st.txOut = 1'b0;
                if (tick16) begin
                    next_st.txTick = st.txTick + 4'h1;
                    if (st.txTick == 4'hF) begin
                        next_st.txSt = LINK_DATA;
                        next_st.txBit = 4'h0;
                    end
                end
            end
            LINK_DATA: begin
                next_st.txOut = st.txSh[0];
                if (tick16) begin
                    next_st.txTick = st.txTick + 4'h1;
                    if (st.txTick == 4'hF) begin
                        next_st.txSh = st.txSh >> 1;
                        next_st.txBit = st.txBit + 4'h1;
                        if (st.txBit + 4'h1 == nBits) begin
                            next_st.txSt = LINK_STOP;
                            next_st.txBit = 4'h0;
                        end
                    end
                end
            end
            LINK_STOP: begin
                next_st.txOut = 1'b1;
                if (tick16) begin
                    next_st.txTick = st.txTick + 4'h1;
                    if (st.txTick == 4'hF) begin
                        next_st.txBit = st.txBit + 4'h1;
                        if (st.txBit + 4'h1 == txStops) next_st.txSt = LINK_IDLE;
                    end
                end
            end
            default: next_st.txSt = LINK_IDLE;
        endcase
        case (st.rxSt)
            LINK_IDLE: begin
                if (!rxLine) begin
                    next_st.rxSt = LINK_START;
                    next_st.rxTick = 4'h0;
                end
            end
            LINK_START: begin
                if (tick16) begin
                    next_st.rxTick = st.rxTick + 4'h1;
                    if (st.rxTick == 4'(`HALF_BIT - 5'h01)) begin
                        next_st.rxTick = 4'h0;
                        next_st.rxBit = 4'h0;
                        next_st.rxSh = 9'h000;
                        next_st.rxSt = rxLine ? LINK_IDLE : LINK_DATA;
                    end
                end
            end
            LINK_DATA: begin
                if (tick16) begin
                    next_st.rxTick = st.rxTick + 4'h1;
                    if (st.rxTick == 4'hF) begin
                        next_st.rxSh = {rxLine, st.rxSh[8:1]};
                        next_st.rxBit = st.rxBit + 4'h1;
                        if (st.rxBit + 4'h1 == nBits) next_st.rxSt = LINK_STOP;
                    end
                end
            end
            LINK_STOP: begin
                if (tick16) begin
                    next_st.rxTick = st.rxTick + 4'h1;
                    if (st.rxTick == 4'hF) begin
                        next_st.rxSt = LINK_IDLE;
                        next_st.done = 1'b1;
                        next_st.ferr = ~rxLine;
                        next_st.data = 8'(rxWord) & (8'hFF >> (2'h3 - wordLen));
                        next_st.ninth = rxWord[4'h5 + {2'b00, wordLen}];
                        // No parity check while the ninth bit carries the address flag
                        next_st.perr = parityEn && !nineBit &&
                            ((^(rxWord & (9'h1FF >> (4'h3 - {2'b00, wordLen}))))
                             != ~parityEven);
                    end
                end
            end
            default: next_st.rxSt = LINK_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{txSt: LINK_IDLE, rxSt: LINK_IDLE, txOut: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end
endmodule : uart_link

// [logic/uart_network_addressable.sv]
// UART with 16450-style registers, fractional baud divider and network address mode
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_network_addressable
    import uart_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] writeData,
    input  wire logic       writeStrobe,
    input  wire logic       readStrobe,
    output logic [7:0]      readData,
    output logic            txLine,
    input  wire logic       rxLine,
    output logic            irq
);
    typedef struct packed {
        logic [7:0]  rdata;
        logic [7:0]  txHold;
        logic        txPending;
        logic        txNinth;
        logic [7:0]  rxBuf;
        logic        rxFull;
        logic        overrun;
        logic        parityErr;
        logic        frameErr;
        logic [7:0]  ien;
        logic [7:0]  lcr;
        logic [7:0]  mcr;
        logic [7:0]  scratch;
        logic [15:0] divisor;
        logic [15:0] frac;
        logic [7:0]  nen;
        logic [3:0]  niid;
        logic [7:0]  nadr;
        logic [2:0]  cdBits;
        logic [3:0]  istat;
        logic [3:0]  imask;
    } regs_t;
    regs_t st, next_st;

    logic       tick16;
    logic       txStart;
    logic       txBusy;
    logic       rxDone;
    logic [7:0] rxData;
    logic       rxNinth;
    logic       rxParityErr;
    logic       rxFrameErr;
    logic       netMode;
    logic       fracEnable;
    logic       txEmpty;
    logic [3:0] events;
    logic       addrMatch;

    assign netMode = st.nen[`NEN_ENABLE];
    assign fracEnable = st.frac != `RESET_FRAC;
    assign txEmpty = !st.txPending;
    assign txStart = st.txPending && !txBusy;
    assign readData = st.rdata;
    assign irq = |(st.istat & st.imask);
    assign addrMatch = rxDone && netMode && rxNinth && (rxData == st.nadr);

    function automatic logic sel(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction : sel

    uart_baud_gen baudGen (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .clockDivBits (st.cdBits),
        .divisor      (st.divisor),
        .fracDiv      (st.frac),
        .fracEnable   (fracEnable),
        .tick16       (tick16)
    );

    uart_link link (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .tick16      (tick16),
        .wordLen     (st.lcr[1:0]),
        .twoStop     (st.lcr[`LCR_STB]),
        .parityEn    (st.lcr[`LCR_PEN]),
        .parityEven  (st.lcr[`LCR_EPS]),
        .nineBit     (netMode),
        .ninthTx     (st.txNinth),
        .txStart     (txStart),
        .txData      (st.txHold),
        .txBusy      (txBusy),
        .txLine      (txLine),
        .rxLine      (rxLine),
        .rxDone      (rxDone),
        .rxData      (rxData),
        .rxNinth     (rxNinth),
        .rxParityErr (rxParityErr),
        .rxFrameErr  (rxFrameErr)
    );

    // Interrupt events: receive, transmit holding register emptied, line error, address match
    always_comb begin
        events = 4'h0;
        // In network mode address frames never land in the buffer
        events[`EV_RX] = rxDone && st.ien[`IEN_RXFULL] && (!netMode || !rxNinth);
        events[`EV_TX] = txStart && st.ien[`IEN_TXEMPTY];
        events[`EV_LINE] = rxDone && st.ien[`IEN_LINE] && (rxParityErr || rxFrameErr);
        events[`EV_ADDR] = addrMatch && st.ien[`IEN_RXFULL];
    end

    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (txStart) next_st.txPending = 1'b0;
        if (readStrobe) begin
            case (regAddr)
                `OFS_DATA: begin
                    if (st.lcr[`LCR_DLAB]) begin
                        next_st.rdata = st.divisor[7:0];
                    end else begin
                        next_st.rdata = st.rxBuf;
                        next_st.rxFull = 1'b0;
                    end
                end
                `OFS_IEN:   next_st.rdata = st.ien;
                `OFS_IID:   next_st.rdata = {7'h00, ~irq};
                `OFS_LCR:   next_st.rdata = st.lcr;
                `OFS_MCR:   next_st.rdata = st.mcr;
                `OFS_LSR: begin
                    next_st.rdata = {1'b0, txEmpty && !txBusy, txEmpty, 1'b0,
                                     st.frameErr, st.parityErr, st.overrun, st.rxFull};
                    next_st.overrun = 1'b0;
                    next_st.parityErr = 1'b0;
                    next_st.frameErr = 1'b0;
                end
                `OFS_MSR:   next_st.rdata = 8'h00;
                `OFS_SCR:   next_st.rdata = st.scratch;
                `OFS_FRAC:  next_st.rdata = st.frac[7:0];
                `OFS_NEN:   next_st.rdata = st.nen;
                `OFS_NIID:  next_st.rdata = {4'h0, st.niid};
                `OFS_NADR:  next_st.rdata = st.nadr;
                `OFS_DIVH:  next_st.rdata = st.divisor[15:8];
                `OFS_ISTAT: next_st.rdata = {4'h0, st.istat};
                `OFS_IMASK: next_st.rdata = {4'h0, st.imask};
                `OFS_CD:    next_st.rdata = {st.frac[15:11], st.cdBits};
                default:    next_st.rdata = 8'h00;
            endcase
            if (sel(regAddr, `OFS_NIID)) next_st.niid = 4'h0;
        end
        if (writeStrobe) begin
            case (regAddr)
                `OFS_DATA: begin
                    if (st.lcr[`LCR_DLAB]) begin
                        next_st.divisor[7:0] = writeData;
                    end else if (!st.txPending) begin
                        // A write while a byte still waits is dropped; software polls empty
                        next_st.txHold = writeData;
                        next_st.txPending = 1'b1;
                        next_st.txNinth = st.nen[`NEN_ADDRFLAG];
                    end
                end
                `OFS_IEN:   next_st.ien = writeData;
                `OFS_LCR:   next_st.lcr = writeData;
                `OFS_MCR:   next_st.mcr = writeData;
                `OFS_SCR:   next_st.scratch = writeData;
                `OFS_FRAC:  next_st.frac[7:0] = writeData;
                `OFS_NEN:   next_st.nen = writeData;
                `OFS_NADR:  next_st.nadr = writeData;
                `OFS_DIVH:  next_st.divisor[15:8] = writeData;
                `OFS_ISTAT: next_st.istat = st.istat & ~writeData[3:0];
                `OFS_IMASK: next_st.imask = writeData[3:0];
                `OFS_CD: begin
                    next_st.cdBits = writeData[2:0];
                    next_st.frac[15:11] = writeData[7:3];
                end
                default: ;
            endcase
        end
        if (rxDone && (!netMode || !rxNinth)) begin
            if (st.rxFull) next_st.overrun = 1'b1;
            next_st.rxBuf = rxData;
            next_st.rxFull = 1'b1;
            // Set wins over a status read clearing the flags in the same cycle
            next_st.parityErr = next_st.parityErr | rxParityErr;
            next_st.frameErr = next_st.frameErr | rxFrameErr;
        end
        if (addrMatch) next_st.niid[0] = 1'b1;
        // Hardware set wins over a software clear in the same cycle
        next_st.istat = next_st.istat | events;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{divisor: `RESET_DIV, frac: `RESET_FRAC, lcr: `RESET_LCR,
                    default: '0};
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    read_latency_a: assert property (readStrobe && regAddr == `OFS_SCR
        |=> readData == $past(st.scratch)) else $error("scratch read wrong");
    dlab_route_a: assert property (writeStrobe && regAddr == `OFS_DATA && st.lcr[`LCR_DLAB]
        |=> st.divisor[7:0] == $past(writeData) && !$rose(st.txPending))
        else $error("divisor low not written");
    niid_reserved_a: assert property (readStrobe && regAddr == `OFS_NIID
        |=> readData[7:4] == 4'h0)
        else $error("reserved ident bits set");
    addr_irq_a: assert property (addrMatch && st.ien[0] |=> st.istat[3])
        else $error("address event lost");
    addr_gate_a: assert property (!st.ien[`IEN_RXFULL] |=> !$rose(st.istat[`EV_ADDR]))
        else $error("address event without enable");
    match_ident_a: assert property (addrMatch |=> st.niid[0])
        else $error("match not flagged");
    ninth_capture_a: assert property (writeStrobe && regAddr == `OFS_DATA && !st.lcr[7]
        && !st.txPending |=> st.txNinth == $past(st.nen[0]))
        else $error("address flag not captured");
    net_parity_a: assert property (netMode && rxDone |-> !rxParityErr)
        else $error("parity checked in network mode");
    irq_level_a: assert property (rxDone && !netMode && st.ien[`IEN_RXFULL]
        && st.imask[`EV_RX] && !writeStrobe |=> irq)
        else $error("irq not raised");
    reset_state_a: assert property ($fell(sys_rst) |-> !netMode && st.ien == 8'h00)
        else $error("bad reset state");

    tx_cover_c: cover property (txStart);
    rx_cover_c: cover property (rxDone && !rxNinth);
    match_cover_c: cover property (addrMatch);
endmodule : uart_network_addressable

// [logic/uart_pkg.sv]
// Types shared by the UART modules
package uart_pkg;
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b00,
        LINK_START = 2'b01,
        LINK_DATA  = 2'b11,
        LINK_STOP  = 2'b10
    } link_state_t;
endpackage : uart_pkg

// [testbench/tb_uart_network_addressable.sv]
// Self-checking bench: registers, frames both ways, network mode, interrupt
`timescale 1ns/1ps
module tb_uart_network_addressable;
    logic        clock, sys_rst, writeStrobe, readStrobe, txLine, rxLine, irq;
    logic [3:0]  regAddr, bitCount;
    logic [7:0]  writeData, readData, rv, d, a;
    logic [15:0] bitClocks;
    logic [8:0]  txq[$];
    int          bad_count, checks;

    uart_network_addressable i_uart_network_addressable (.clock(clock), .sys_rst(sys_rst),
        .regAddr(regAddr), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData), .txLine(txLine), .rxLine(rxLine),
        .irq(irq));
    uart_peer i_uart_peer (.clock(clock), .txLine(txLine), .bitClocks(bitClocks),
        .bitCount(bitCount), .rxLine(rxLine));

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clock);
        regAddr     <= ad;
        writeData   <= v;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] ad);
        @(posedge clock);
        regAddr    <= ad;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 rv = readData;
    endtask : rd

    // Polls a register until a masked bit rises; running out ends the run
    task automatic waitReg(input logic [3:0] ad, input logic [7:0] m);
        for (int i = 0; i < 3000; i++) begin
            rd(ad);
            if ((rv & m) != 8'h00) return;
        end
        chk(1'b0, 1'b1, "wait bound");
        summarize();
    endtask : waitReg

    task automatic sendTx(input logic [7:0] v, input logic ninth);
        txq.push_back({ninth, v});
        wr(4'h0, v);
        for (int i = 0; i < 4000 && i_uart_peer.got.size() == 0; i++) @(posedge clock);
        if (i_uart_peer.got.size() == 0) begin
            chk(1'b0, 1'b1, "tx bound");
            summarize();
        end
        chk(i_uart_peer.got.pop_front(), txq.pop_front(), "tx frame");
    endtask : sendTx

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        sys_rst = 1'b1;
        regAddr = 4'h0;
        writeData = 8'h00;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        bitClocks = 16'h0020;
        bitCount = 4'h8;
        bad_count = 0;
        checks = 0;
        void'($urandom(95));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd(4'h3);
        chk(rv, 8'h03, "lcr reset");
        rd(4'h1);
        chk(rv, 8'h00, "ien reset");
        rd(4'h9);
        chk(rv, 8'h00, "nen reset");
        chk(irq, 1'b0, "irq reset");
        $display("test reset done");
        d = $urandom;
        wr(4'h7, d);
        rd(4'h7);
        chk(rv, d, "scratch");
        @(posedge clock);
        #1 chk(readData, 8'h00, "read data one cycle");
        wr(4'h3, 8'h83);
        wr(4'h0, 8'h02);
        wr(4'hC, 8'h00);
        rd(4'h0);
        chk(rv, 8'h02, "divisor low");
        wr(4'h3, 8'h03);
        bitClocks = 16'h0040;
        $display("test registers done");
        for (int k = 0; k < 2; k++) sendTx($urandom, 1'b0);
        wr(4'hF, 8'h09);
        bitClocks = 16'h0080;
        sendTx($urandom, 1'b0);
        wr(4'hF, 8'h08);
        bitClocks = 16'h0040;
        wr(4'h8, 8'h80);
        bitClocks = 16'h0044;
        sendTx($urandom, 1'b0);
        wr(4'h8, 8'h00);
        bitClocks = 16'h0040;
        wr(4'h3, 8'h06);
        bitCount = 4'h7;
        sendTx(8'($urandom) & 8'h7F, 1'b0);
        repeat (100) @(posedge clock);
        wr(4'h3, 8'h03);
        bitCount = 4'h8;
        $display("test transmit done");
        wr(4'h1, 8'h01);
        wr(4'hE, 8'h01);
        d = $urandom;
        i_uart_peer.send({1'b0, d});
        waitReg(4'h5, 8'h01);
        rd(4'h0);
        chk(rv, d, "rx byte");
        chk(irq, 1'b1, "irq set");
        wr(4'hE, 8'h00);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b0, "irq masked");
        wr(4'hE, 8'h01);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b1, "irq unmasked");
        wr(4'hD, 8'h01);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b0, "irq cleared");
        $display("test receive done");
        wr(4'h3, 8'h0B);
        bitCount = 4'h9;
        for (int p = 0; p < 2; p++) begin
            i_uart_peer.send({(p == 1) ? ~^d : ^d, d});
            waitReg(4'h5, 8'h01);
            chk(rv[2], p == 0, "parity flag");
            rd(4'h0);
        end
        wr(4'hD, 8'h0F);
        $display("test parity done");
        wr(4'h3, 8'h03);
        a = $urandom;
        wr(4'hB, a);
        wr(4'h1, 8'h01);
        wr(4'h9, 8'h81);
        sendTx($urandom, 1'b1);
        waitReg(4'h5, 8'h20);
        wr(4'h9, 8'h80);
        sendTx($urandom, 1'b0);
        wr(4'h3, 8'h0B);
        i_uart_peer.send({1'b1, a});
        waitReg(4'hA, 8'h0F);
        chk(rv[7:4], 4'h0, "ident upper");
        rd(4'h5);
        chk(rv[0], 1'b0, "address not buffered");
        rd(4'hD);
        chk(rv[3], 1'b1, "address match");
        i_uart_peer.send({1'b0, 8'h55});
        waitReg(4'h5, 8'h01);
        chk(rv[2], 1'b0, "no parity check");
        rd(4'h0);
        chk(rv, 8'h55, "network data");
        $display("test network done");
        summarize();
    end
endmodule : tb_uart_network_addressable

// [testbench/uart_peer.sv]
// Remote serial device: sends frames to the receiver, captures the transmitter's frames
`timescale 1ns/1ps
module uart_peer (
    input  wire logic        clock,
    input  wire logic        txLine,
    input  wire logic [15:0] bitClocks,
    input  wire logic [3:0]  bitCount,
    output logic             rxLine
);
    logic [8:0] got[$];

    initial rxLine = 1'b1;

    // Start low, data bits LSB first, one stop high; the line then idles high
    task automatic send(input logic [8:0] frame);
        for (int i = 0; i < bitCount + 2; i++) begin
            rxLine <= (i == 0) ? 1'b0 : (i > bitCount) ? 1'b1 : frame[i-1];
            repeat (bitClocks) @(posedge clock);
        end
    endtask : send

    // Samples mid-bit; a frame without a high stop bit is dropped so the bench times out
    always begin
        logic [8:0] v;
        @(negedge txLine);
        v = '0;
        repeat (bitClocks / 2) @(posedge clock);
        for (int i = 0; i < bitCount; i++) begin
            repeat (bitClocks) @(posedge clock);
            v[i] = txLine;
        end
        repeat (bitClocks) @(posedge clock);
        if (txLine === 1'b1) got.push_back(v);
    end
endmodule : uart_peer
